//--- mac_defs.svh
/*
 * Offsets, field positions, reset values and fixed codes of the
 * multiply-accumulate slice.
 * Assumes inclusion by bare name from every file that needs a constant.
 */
`ifndef MAC_DEFS_SVH
`define MAC_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define MAC_OFF_CTRL      8'h00
`define MAC_OFF_PAT_LO    8'h04
`define MAC_OFF_PAT_HI    8'h08
`define MAC_OFF_MSK_LO    8'h0c
`define MAC_OFF_MSK_HI    8'h10
`define MAC_OFF_RES_LO    8'h14
`define MAC_OFF_RES_HI    8'h18
`define MAC_OFF_STAT      8'h1c

// ==========================================================================
// Control register fields
`define MAC_CTRL_W        19
`define MAC_CTRL_RST      19'h40000
`define MAC_F_BYPASS      0
`define MAC_F_SIMD_LO     1
`define MAC_F_SIMD_HI     2
`define MAC_F_OP_LO       3
`define MAC_F_OP_HI       4
`define MAC_F_LOGIC_EN    5
`define MAC_F_LSEL_LO     6
`define MAC_F_LSEL_HI     9
`define MAC_F_XW_LO       10
`define MAC_F_XW_HI       11
`define MAC_F_CNT_EN      12
`define MAC_F_CNT_DOWN    13
`define MAC_F_PRE_SUB     14
`define MAC_F_PRE_EN      15
`define MAC_F_AREG        16
`define MAC_F_MREG        17
`define MAC_F_PREG        18

// ==========================================================================
// Pattern, mask and status layout
`define MAC_HI_W          16
`define MAC_PAT_RST       48'h0000_0000_0000
`define MAC_MSK_RST       48'h0000_0000_0000
`define MAC_ST_MATCH      0
`define MAC_ST_MATCH_INV  1
`define MAC_ST_WIDE       2
`define MAC_ST_PAR_LO     8
`define MAC_ST_PAR_HI     15

// ==========================================================================
// Lane starts per SIMD mode, one bit per 12-bit segment
`define MAC_LS_ONE        4'h1
`define MAC_LS_TWO        4'h5
`define MAC_LS_FOUR       4'hf
`define MAC_SEG_ONE       12'h001

`endif

//--- mac_fab_model.sv
/* Fabric user logic that feeds operands to mac_slice.
   Assumes the bench calls put right after a rising pclk edge. */
`timescale 1ns/1ps
module mac_fab_model (
   output logic [26:0] op_a,
   output logic [26:0] op_d,
   output logic [17:0] op_b,
   output logic [47:0] op_ab,
   output logic [47:0] op_c
);
   // =====================================================================
   // Operand launch; NBA so the slice samples them one edge later
   task automatic put(input logic [26:0] a, input logic [26:0] d, input logic [17:0] b,
                      input logic [47:0] ab, input logic [47:0] c);
      op_a  <= a;
      op_d  <= d;
      op_b  <= b;
      op_ab <= ab;
      op_c  <= c;
   endtask : put

   initial begin
      put('0, '0, '0, '0, '0);
   end
endmodule : mac_fab_model

//--- mac_pkg.sv
/*
 * Types and the bitwise logic function of the multiply-accumulate slice.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mac_pkg;

   // =======================================================================
   // Mode encodings
   typedef enum logic [1:0] {
      MAC_SIMD_ONE48  = 2'h0,
      MAC_SIMD_TWO24  = 2'h1,
      MAC_SIMD_FOUR12 = 2'h2
   } mac_simd_e;

   typedef enum logic [1:0] {
      MAC_OP_ADD    = 2'h0,
      MAC_OP_SUB    = 2'h1,
      MAC_OP_ACC    = 2'h2,
      MAC_OP_ACCSUB = 2'h3
   } mac_op_e;

   typedef enum logic [3:0] {
      MAC_LF_AND   = 4'h0,
      MAC_LF_OR    = 4'h1,
      MAC_LF_XOR   = 4'h2,
      MAC_LF_NAND  = 4'h3,
      MAC_LF_NOR   = 4'h4,
      MAC_LF_XNOR  = 4'h5,
      MAC_LF_ANDNZ = 4'h6,
      MAC_LF_ORNZ  = 4'h7,
      MAC_LF_NXAND = 4'h8,
      MAC_LF_NXOR  = 4'h9
   } mac_lfn_e;

   typedef enum logic [1:0] {
      MAC_XW_12 = 2'h0,
      MAC_XW_24 = 2'h1,
      MAC_XW_48 = 2'h2,
      MAC_XW_96 = 2'h3
   } mac_xw_e;

   typedef logic [47:0] mac_word_t;

   // =======================================================================
   // Ten logic functions; codes above nine give zero
   function automatic mac_word_t mac_logic(input mac_word_t x,
                                           input mac_word_t z,
                                           input logic [3:0] sel);
      mac_word_t r;
      r = '0;
      case (sel)
         MAC_LF_AND:   r = x & z;
         MAC_LF_OR:    r = x | z;
         MAC_LF_XOR:   r = x ^ z;
         MAC_LF_NAND:  r = ~(x & z);
         MAC_LF_NOR:   r = ~(x | z);
         MAC_LF_XNOR:  r = ~(x ^ z);
         MAC_LF_ANDNZ: r = x & ~z;
         MAC_LF_ORNZ:  r = x | ~z;
         MAC_LF_NXAND: r = ~x & z;
         MAC_LF_NXOR:  r = ~x | z;
         default:      r = '0;
      endcase
      return r;
   endfunction : mac_logic

endpackage : mac_pkg

//--- mac_simd_add.sv
/*
 * Segmented adder: carries are cut at lane starts so lanes stay independent.
 * Assumes the caller sets lane_start bit 0 and picks the lane pattern.
 */
`timescale 1ns/1ps
module mac_simd_add #(
   parameter int SEG_W = 12,
   parameter int SEGS  = 4
) (
   input  wire logic [SEG_W*SEGS-1:0] a,
   input  wire logic [SEG_W*SEGS-1:0] b,
   input  wire logic                  sub,
   input  wire logic [SEGS-1:0]       lane_start,
   output logic      [SEG_W*SEGS-1:0] sum
);

   logic [SEGS:0] carry;

   assign carry[0] = sub;

   // =======================================================================
   // One segment per iteration; wrap is natural, no saturation
   for (genvar k = 0; k < SEGS; k++) begin : g_seg
      logic             cin;
      logic [SEG_W:0]   s;
      assign cin = lane_start[k] ? sub : carry[k];
      assign s   = {1'b0, a[k*SEG_W +: SEG_W]}
                 + {1'b0, b[k*SEG_W +: SEG_W] ^ {SEG_W{sub}}}
                 + {{SEG_W{1'b0}}, cin};
      assign sum[k*SEG_W +: SEG_W] = s[SEG_W-1:0];
      assign carry[k+1]            = s[SEG_W];
   end

endmodule : mac_simd_add

//--- mac_slice.sv
/*
 * Multiply-accumulate slice with pre-adder, SIMD adder, logic unit,
 * wide XOR, pattern detector and an APB slave for its configuration.
 * Assumes operands come from fabric logic on pclk; srst is synchronous.
 */
// Added by the designer: the placing of the registers and the APB interface to the registers.
// How it works
// - 27x18 signed product is added into a 48-bit accumulator.
// - Run-time bypass sends two 48-bit operands straight to the adder.
// - Adder splits into two 24-bit or four 12-bit carry-free lanes.
// - Logic unit outputs one of ten bitwise functions of operands.
// - Pre-adder adds or subtracts a second operand before multiplying.
// - 96-bit XOR gives parity over 12, 24, 48 or 96-bit segments.
// - Pattern detector compares result to masked pattern, for rounding.
// - Two successive matches combine into a 96-bit wide match flag.
// - Accumulator counts up or down by one in each lane on each enabled clock.
`timescale 1ns/1ps
`include "mac_defs.svh"
module mac_slice #(
   parameter int A_W    = 27,
   parameter int B_W    = 18,
   parameter int P_W    = 48,
   parameter int SEG_W  = 12,
   parameter int ADDR_W = 8
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic              srst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [A_W-1:0]    op_a,
   input  wire logic [A_W-1:0]    op_d,
   input  wire logic [B_W-1:0]    op_b,
   input  wire logic [P_W-1:0]    op_ab,
   input  wire logic [P_W-1:0]    op_c,
   output logic      [P_W-1:0]    p_out,
   output logic                   pat_match,
   output logic                   pat_match_inv,
   output logic                   wide_match,
   output logic      [7:0]        parity
);

   localparam int SEGS = P_W / SEG_W;

   // =======================================================================
   // Elaboration checks
   if (P_W != 48 || SEG_W != 12 || A_W + B_W > P_W || A_W < 2 || B_W < 2) begin : g_chk
      $error("mac_slice: unsupported widths");
   end

   // =======================================================================
   // Configuration registers
   logic [`MAC_CTRL_W-1:0] ctrl_q;
   logic [P_W-1:0]         pat_q;
   logic [P_W-1:0]         msk_q;
   logic                   wr_en;
   logic                   acc_done;

   assign acc_done = psel & penable & ce;
   assign wr_en    = acc_done & pwrite & ~pslverr;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `MAC_CTRL_RST;
      end else if (wr_en && paddr == `MAC_OFF_CTRL) begin
         ctrl_q <= pwdata[`MAC_CTRL_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pat_q <= `MAC_PAT_RST;
         msk_q <= `MAC_MSK_RST;
      end else if (wr_en) begin
         unique case (paddr)
            `MAC_OFF_PAT_LO: pat_q[31:0]  <= pwdata;
            `MAC_OFF_PAT_HI: pat_q[P_W-1:32] <= pwdata[`MAC_HI_W-1:0];
            `MAC_OFF_MSK_LO: msk_q[31:0]  <= pwdata;
            `MAC_OFF_MSK_HI: msk_q[P_W-1:32] <= pwdata[`MAC_HI_W-1:0];
            default: ;
         endcase
      end
   end

   mac_pkg::mac_simd_e simd;
   mac_pkg::mac_op_e   op;
   mac_pkg::mac_xw_e   xw;
   logic               bypass;
   logic               logic_en;
   logic [3:0]         lsel;
   logic               cnt_en;
   logic               cnt_down;
   logic               pre_sub;
   logic               pre_en;
   logic               areg;
   logic               mreg;
   logic               preg;

   assign bypass   = ctrl_q[`MAC_F_BYPASS];
   assign simd     = mac_pkg::mac_simd_e'(ctrl_q[`MAC_F_SIMD_HI:`MAC_F_SIMD_LO]);
   assign op       = mac_pkg::mac_op_e'(ctrl_q[`MAC_F_OP_HI:`MAC_F_OP_LO]);
   assign logic_en = ctrl_q[`MAC_F_LOGIC_EN];
   assign lsel     = ctrl_q[`MAC_F_LSEL_HI:`MAC_F_LSEL_LO];
   assign xw       = mac_pkg::mac_xw_e'(ctrl_q[`MAC_F_XW_HI:`MAC_F_XW_LO]);
   assign cnt_en   = ctrl_q[`MAC_F_CNT_EN];
   assign cnt_down = ctrl_q[`MAC_F_CNT_DOWN];
   assign pre_sub  = ctrl_q[`MAC_F_PRE_SUB];
   assign pre_en   = ctrl_q[`MAC_F_PRE_EN];
   assign areg     = ctrl_q[`MAC_F_AREG];
   assign mreg     = ctrl_q[`MAC_F_MREG];
   assign preg     = ctrl_q[`MAC_F_PREG];

   // =======================================================================
   // Input stage
   logic [A_W-1:0] a_q, d_q, a_s, d_s;
   logic [B_W-1:0] b_q, b_s;
   logic [P_W-1:0] ab_q, c_q, ab_s, c_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_q  <= '0;
         d_q  <= '0;
         b_q  <= '0;
         ab_q <= '0;
         c_q  <= '0;
      end else if (ce) begin
         if (srst) begin
            a_q  <= '0;
            d_q  <= '0;
            b_q  <= '0;
            ab_q <= '0;
            c_q  <= '0;
         end else begin
            a_q  <= op_a;
            d_q  <= op_d;
            b_q  <= op_b;
            ab_q <= op_ab;
            c_q  <= op_c;
         end
      end
   end

   // Bypassed stages cost no cycle
   assign a_s  = areg ? a_q  : op_a;
   assign d_s  = areg ? d_q  : op_d;
   assign b_s  = areg ? b_q  : op_b;
   assign ab_s = areg ? ab_q : op_ab;
   assign c_s  = areg ? c_q  : op_c;

   // =======================================================================
   // Pre-adder and multiplier
   logic        [A_W-1:0]     d_g;
   logic        [A_W-1:0]     pre;
   logic signed [A_W+B_W-1:0] prod;
   logic        [P_W-1:0]     prod_x;

   assign d_g  = pre_en ? d_s : '0;
   assign pre  = pre_sub ? a_s - d_g : a_s + d_g;
   assign prod = $signed(pre) * $signed(b_s);
   assign prod_x = {{(P_W-A_W-B_W){prod[A_W+B_W-1]}}, prod};

   // =======================================================================
   // Multiplier stage
   logic [P_W-1:0] x_q, z_q, x_s, z_s, x_m;

   assign x_m = bypass ? ab_s : prod_x;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_q <= '0;
         z_q <= '0;
      end else if (ce) begin
         if (srst) begin
            x_q <= '0;
            z_q <= '0;
         end else begin
            x_q <= x_m;
            z_q <= c_s;
         end
      end
   end

   assign x_s = mreg ? x_q : x_m;
   assign z_s = mreg ? z_q : c_s;

   // =======================================================================
   // Arithmetic and logic stage
   logic [P_W-1:0]  acc_q;
   logic [SEGS-1:0] lane_start;
   logic [P_W-1:0]  step;
   logic [P_W-1:0]  add_a, add_b, sum, alu_d;
   logic            add_sub;

   always_comb begin
      unique case (simd)
         mac_pkg::MAC_SIMD_TWO24:  lane_start = `MAC_LS_TWO;
         mac_pkg::MAC_SIMD_FOUR12: lane_start = `MAC_LS_FOUR;
         default:                  lane_start = `MAC_LS_ONE;
      endcase
   end

   // A one in the bottom bit of every lane
   for (genvar k = 0; k < SEGS; k++) begin : g_step
      assign step[k*SEG_W +: SEG_W] = lane_start[k] ? `MAC_SEG_ONE : '0;
   end

   always_comb begin
      add_a   = z_s;
      add_b   = x_s;
      add_sub = 1'b0;
      if (cnt_en) begin
         add_a   = acc_q;
         add_b   = step;
         add_sub = cnt_down;
      end else begin
         unique case (op)
            mac_pkg::MAC_OP_SUB: add_sub = 1'b1;
            mac_pkg::MAC_OP_ACC: add_a = acc_q;
            mac_pkg::MAC_OP_ACCSUB: begin
               add_a   = acc_q;
               add_sub = 1'b1;
            end
            default: ;
         endcase
      end
   end

   mac_simd_add #(
      .SEG_W (SEG_W),
      .SEGS  (SEGS)
   ) u_add (
      .a          (add_a),
      .b          (add_b),
      .sub        (add_sub),
      .lane_start (lane_start),
      .sum        (sum)
   );

   // Counting takes priority over the logic unit
   assign alu_d = (logic_en && !cnt_en) ? mac_pkg::mac_logic(x_s, z_s, lsel)
                                        : sum;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= '0;
      end else if (ce) begin
         if (srst) begin
            acc_q <= '0;
         end else begin
            acc_q <= alu_d;
         end
      end
   end

   // Accumulate feedback always uses acc_q, so an unregistered output only
   // removes the cycle from the forward path
   assign p_out = preg ? acc_q : alu_d;

   // =======================================================================
   // Pattern detector
   logic m_now, mi_now, m_prev_q;

   assign m_now  = ((p_out ^ pat_q) & ~msk_q) == '0;
   assign mi_now = ((p_out ^ ~pat_q) & ~msk_q) == '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pat_match     <= 1'b0;
         pat_match_inv <= 1'b0;
         wide_match    <= 1'b0;
         m_prev_q      <= 1'b0;
      end else if (ce) begin
         if (srst) begin
            pat_match     <= 1'b0;
            pat_match_inv <= 1'b0;
            wide_match    <= 1'b0;
            m_prev_q      <= 1'b0;
         end else begin
            pat_match     <= m_now;
            pat_match_inv <= mi_now;
            m_prev_q      <= m_now;
            wide_match    <= m_now & m_prev_q;
         end
      end
   end

   // =======================================================================
   // Wide XOR over {z, x}
   logic [2*P_W-1:0]  xin;
   logic [2*SEGS-1:0] seg_par;
   logic [7:0]        par_d;

   assign xin = {z_s, x_s};

   for (genvar k = 0; k < 2*SEGS; k++) begin : g_par
      assign seg_par[k] = ^xin[k*SEG_W +: SEG_W];
   end

   always_comb begin
      par_d = '0;
      unique case (xw)
         mac_pkg::MAC_XW_12: par_d = seg_par;
         mac_pkg::MAC_XW_24: begin
            for (int i = 0; i < 4; i++) begin
               par_d[i] = seg_par[2*i] ^ seg_par[2*i+1];
            end
         end
         mac_pkg::MAC_XW_48: begin
            par_d[0] = ^seg_par[3:0];
            par_d[1] = ^seg_par[7:4];
         end
         default: par_d[0] = ^seg_par;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         parity <= '0;
      end else if (ce) begin
         parity <= srst ? '0 : par_d;
      end
   end

   // =======================================================================
   // APB read path: data captured in the setup cycle
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      return a == `MAC_OFF_CTRL   || a == `MAC_OFF_PAT_LO || a == `MAC_OFF_PAT_HI ||
             a == `MAC_OFF_MSK_LO || a == `MAC_OFF_MSK_HI || a == `MAC_OFF_RES_LO ||
             a == `MAC_OFF_RES_HI || a == `MAC_OFF_STAT;
   endfunction : addr_ok

   function automatic logic addr_ro(input logic [ADDR_W-1:0] a);
      return a == `MAC_OFF_RES_LO || a == `MAC_OFF_RES_HI || a == `MAC_OFF_STAT;
   endfunction : addr_ro

   logic [31:0] rd_d;

   always_comb begin
      rd_d = '0;
      unique case (paddr)
         `MAC_OFF_CTRL:   rd_d[`MAC_CTRL_W-1:0] = ctrl_q;
         `MAC_OFF_PAT_LO: rd_d = pat_q[31:0];
         `MAC_OFF_PAT_HI: rd_d[`MAC_HI_W-1:0] = pat_q[P_W-1:32];
         `MAC_OFF_MSK_LO: rd_d = msk_q[31:0];
         `MAC_OFF_MSK_HI: rd_d[`MAC_HI_W-1:0] = msk_q[P_W-1:32];
         `MAC_OFF_RES_LO: rd_d = p_out[31:0];
         `MAC_OFF_RES_HI: rd_d[`MAC_HI_W-1:0] = p_out[P_W-1:32];
         `MAC_OFF_STAT: begin
            rd_d[`MAC_ST_MATCH]     = pat_match;
            rd_d[`MAC_ST_MATCH_INV] = pat_match_inv;
            rd_d[`MAC_ST_WIDE]      = wide_match;
            rd_d[`MAC_ST_PAR_HI:`MAC_ST_PAR_LO] = parity;
         end
         default: rd_d = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (ce && psel && !penable) begin
         prdata <= pwrite ? '0 : rd_d;
      end
   end

   // Frozen slice cannot finish a transfer
   assign pready  = ce;
   assign pslverr = psel & penable & (!addr_ok(paddr) | (pwrite & addr_ro(paddr)));

endmodule : mac_slice

//--- mac_slice_monitor.sv
/* Port checker for mac_slice: bus answers, flag pairing, reset and freeze.
   Assumes a bind onto mac_slice and one pclk domain. */
`timescale 1ns/1ps
module mac_slice_monitor #(
   parameter int ADDR_W = 8
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              ce,
   input wire logic              srst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              pat_match,
   input wire logic              pat_match_inv,
   input wire logic              wide_match,
   input wire logic [7:0]        parity
);
   // =====================================================================
   // Address classes
   logic unmap;
   logic ro_wr;
   assign unmap = (paddr > 8'h1c) || (paddr[1:0] != 2'h0);
   assign ro_wr = pwrite && (paddr >= 8'h14);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // =====================================================================
   // Assertions
   pready_ce_a: assert property (psel |-> pready == ce)
      else $error("pready differs from ce");
   idle_err_a: assert property (!psel |-> !pslverr)
      else $error("pslverr outside a transfer");
   err_bad_a: assert property (psel && penable && (unmap || ro_wr) |-> pslverr)
      else $error("refused access not flagged");
   err_good_a: assert property (psel && penable && !unmap && !ro_wr |-> !pslverr)
      else $error("legal access flagged");
   rd_hold_a: assert property (psel && penable && pready |=> $stable(prdata))
      else $error("prdata moved after access");
   wr_zero_a: assert property (psel && !penable && pwrite && ce |=> prdata == 32'h0)
      else $error("prdata not zero on write");
   bad_rd_a: assert property (psel && !penable && !pwrite && ce && unmap |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   flag_clr_a: assert property (ce && srst |=> !pat_match && !pat_match_inv
      && !wide_match && parity == 8'h00)
      else $error("flags survive sync reset");
   wide_pair_a: assert property (wide_match |-> pat_match && $past(pat_match))
      else $error("wide match without two matches");
   hold_ce_a: assert property (!ce |=> $stable(parity) && $stable(wide_match)
      && $stable(pat_match))
      else $error("state moved with ce low");
endmodule : mac_slice_monitor

//--- tb_top.sv
/* Self-checking bench for mac_slice against a reference model.
   Assumes mac_slice, mac_fab_model and mac_slice_monitor compiled first. */
`timescale 1ns/1ps
module tb_top;
   logic        pclk, presetn, ce, srst, psel, penable, pwrite, pready, pslverr, erv;
   logic        pat_match, pat_match_inv, wide_match, mt;
   logic [7:0]  paddr, parity;
   logic [31:0] pwdata, prdata, seed, rdv;
   logic [26:0] op_a, op_d, va, vd;
   logic [17:0] op_b, vb;
   logic [47:0] op_ab, op_c, p_out, vab, vc, exp_p, pat, msk, w;
   logic [18:0] k;
   int          n_fail, n_compared;

   mac_slice u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .op_a(op_a), .op_d(op_d), .op_b(op_b),
      .op_ab(op_ab), .op_c(op_c), .p_out(p_out), .pat_match(pat_match),
      .pat_match_inv(pat_match_inv), .wide_match(wide_match), .parity(parity));
   mac_fab_model u_fab (.op_a(op_a), .op_d(op_d), .op_b(op_b), .op_ab(op_ab), .op_c(op_c));

   // =====================================================================
   // Reference model
   function automatic logic [47:0] f_alu(input logic [47:0] acc);
      logic signed [26:0] s;
      logic signed [47:0] x;
      logic [47:0] r, m, y, d;
      int lw;
      s = k[15] ? (k[14] ? va - vd : va + vd) : va;
      x = s * $signed(vb);
      if (k[0]) x = vab;
      lw = (k[2:1] == 2'h1) ? 24 : ((k[2:1] == 2'h2) ? 12 : 48);
      y = (k[4] || k[12]) ? acc : vc;
      r = '0;
      for (int i = 0; i < 48; i += lw) begin
         m = ((48'h1 << lw) - 48'h1) << i;
         d = k[12] ? (48'h1 << i) : (x & m);
         r |= ((y & m) + ((k[12] ? k[13] : k[3]) ? -d : d)) & m;
      end
      if (k[5] && !k[12]) case (k[9:6])
         4'h0: r = x & vc;
         4'h1: r = x | vc;
         4'h2: r = x ^ vc;
         4'h3: r = ~(x & vc);
         4'h4: r = ~(x | vc);
         4'h5: r = ~(x ^ vc);
         4'h6: r = x & ~vc;
         4'h7: r = x | ~vc;
         4'h8: r = ~x & vc;
         4'h9: r = ~x | vc;
         default: r = '0;
      endcase
      return r;
   endfunction : f_alu

   function automatic logic [7:0] f_par(input int xw);
      logic [95:0] v;
      logic [7:0] p;
      v = {vc, vab};
      p = '0;
      for (int j = 0; j < 96; j++) p[j / (12 << xw)] ^= v[j];
      return p;
   endfunction : f_par

   function automatic logic [31:0] nxt(input logic [31:0] s);
      for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      return s;
   endfunction : nxt

   // =====================================================================
   // Tasks
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic stop_test();
      if (n_fail == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rdv, erv);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0, rdv, erv);
      chk("prdata", rdv, e);
      chk("pslverr", erv, ee);
   endtask : rd

   task automatic rnd();
      seed = nxt(seed); va = seed[26:0]; vb = seed[31:14];
      seed = nxt(seed); vd = seed[26:0]; vab[47:32] = seed[31:16];
      seed = nxt(seed); vab[31:0] = seed;
      seed = nxt(seed); vc = {seed[15:0], nxt(seed)};
   endtask : rnd

   task automatic put();
      @(posedge pclk);
      u_fab.put(va, vd, vb, vab, vc);
   endtask : put

   // Zero operands keep the accumulator steady while the bus is busy, except when counting is still enabled
   task automatic start_seq(input logic [18:0] kv);
      va = '0; vd = '0; vb = '0; vab = '0; vc = '0;
      put();
      k = kv;
      wr(8'h00, {13'h0, kv});
      @(posedge pclk) srst <= 1'b1;
      @(posedge pclk) srst <= 1'b0;
      exp_p = f_alu(48'h0);
   endtask : start_seq

   task automatic step();
      rnd();
      put();
      @(negedge pclk);
      chk("p_out", p_out, exp_p);
      exp_p = f_alu(exp_p);
   endtask : step

   // =====================================================================
   // Clock, watchdog and scenarios
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // About ten times the expected run length
   initial begin
      #100000;
      n_fail++;
      stop_test();
   end

   initial begin
      {presetn, srst, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1; seed = 32'ha; n_fail = 0; n_compared = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h00, 32'h0004_0000, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      wr(8'h14, 32'hffff_ffff);
      rd(8'h14, 32'h0, 1'b0);
      for (int s = 0; s < 3; s++) for (int o = 0; o < 4; o++) begin
         start_seq(19'h40001 | 19'(s << 1) | 19'(o << 3));
         repeat (6) step();
      end
      for (int p = 0; p < 3; p++) for (int o = 0; o < 4; o += 2) begin
         start_seq(19'h40000 | 19'(o << 3) | 19'(p > 0) << 15 | 19'(p > 1) << 14);
         repeat (5) step();
      end
      for (int l = 0; l < 11; l++) begin
         start_seq(19'h40021 | 19'(l << 6));
         repeat (3) step();
      end
      for (int s = 0; s < 3; s++) for (int d = 0; d < 2; d++) begin
         start_seq(19'h41000 | 19'(d << 13) | 19'(s << 1));
         exp_p = '0;
         repeat (4) begin
            @(negedge pclk);
            chk("count", p_out, exp_p);
            exp_p = f_alu(exp_p);
         end
         @(posedge pclk) ce <= 1'b0;
         @(posedge pclk) ce <= 1'b1;
         @(negedge pclk);
         chk("frozen", p_out, exp_p);
      end
      for (int x = 0; x < 4; x++) begin
         start_seq(19'h40001 | 19'(x << 10));
         rnd();
         put();
         repeat (2) @(negedge pclk);
         chk("parity", parity, f_par(x));
      end
      rnd();
      pat = vab;
      wr(8'h04, pat[31:0]);
      wr(8'h08, {16'h0, pat[47:32]});
      for (int t = 0; t < 3; t++) begin
         msk = (t == 2) ? 48'h1 : 48'h0;
         wr(8'h0c, msk[31:0]);
         start_seq(19'h40001);
         vab = pat ^ 48'((t > 0) ? 1 : 0);
         put();
         mt = ((vab ^ pat) & ~msk) == 48'h0;
         repeat (4) @(negedge pclk);
         chk("match", pat_match, mt);
         chk("match_inv", pat_match_inv, ((vab ^ ~pat) & ~msk) == 48'h0);
         chk("wide", wide_match, mt);
         rd(8'h1c, {16'h0, f_par(0), 5'h0, mt, ((vab ^ ~pat) & ~msk) == 48'h0, mt}, 1'b0);
         rd(8'h18, {16'h0, vab[47:32]}, 1'b0);
      end
      for (int l = 0; l < 2; l++) begin
         start_seq((l > 0) ? 19'h70001 : 19'h00001);
         rd(8'h00, {13'h0, k}, 1'b0);
         rnd();
         vc = '0;
         put();
         w = vab;
         vab = '0;
         if (l == 0) begin
            @(negedge pclk);
            chk("p_out", p_out, w);
         end else begin
            put();
            repeat (2) @(negedge pclk);
            chk("p_out", p_out, 48'h0);
            @(negedge pclk);
            chk("p_out", p_out, w);
         end
      end
      stop_test();
   end
endmodule : tb_top

bind mac_slice mac_slice_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk(pclk), .presetn(presetn),
   .ce(ce), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pat_match(pat_match),
   .pat_match_inv(pat_match_inv), .wide_match(wide_match), .parity(parity));
